//--- verilog/i2cs_data_timeout.sv
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "i2cs_consts.svh"

module i2cs_data_timeout #(
    parameter longint CLK_HZ   = 100000000,
    parameter longint SUB_HZ   = 32768,
    parameter int     TICK_CYC = int'((CLK_HZ * `I2CS_TMO_DIV) / SUB_HZ)
) (
    input  wire logic        MCLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    input  wire logic        SCL_IN,
    output logic             SCL_OUT,
    output logic             SCL_OE_OUT,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_OUT,
    input  wire logic        ADDR_MATCH_IN,
    input  wire logic        ADDR_RW_IN,
    input  wire logic        STOP_DET_IN,
    output logic             IRQ_OUT
);

    i2cs_pkg::i2cs_state_t   state;
    i2cs_pkg::i2cs_state_t   next_state;
    i2cs_pkg::i2cs_ctl_two_t ctl2;
    i2cs_pkg::i2cs_tmo_ctl_t tmo;
    i2cs_pkg::i2cs_irq_t     ist;
    i2cs_pkg::i2cs_irq_t     imsk;
    i2cs_pkg::i2cs_irq_t     ev;

    logic [7:0]  data_buf;
    logic [7:0]  shift;
    logic [2:0]  bit_cnt;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_s3;
    logic        sda_s1;
    logic        sda_s2;
    logic        ph_wr;
    logic [7:0]  ph_addr;
    logic        tmo_run;
    logic [31:0] pre_cnt;
    logic [5:0]  tick_cnt;
    logic [31:0] lk_cyc;

    // Bus decode
    wire       ahb_go    = HSEL_IN & HREADY_IN & HTRANS_IN[1];
    wire [7:0] ap_addr   = HADDR_IN[7:0];
    wire       wr_data   = ph_wr & (ph_addr == `I2CS_OFS_DATA);
    wire       wr_ctl2   = ph_wr & (ph_addr == `I2CS_OFS_CTL2);
    wire       wr_tmo    = ph_wr & (ph_addr == `I2CS_OFS_TMO);
    wire       wr_ist    = ph_wr & (ph_addr == `I2CS_OFS_IST);
    wire       wr_imsk   = ph_wr & (ph_addr == `I2CS_OFS_IMSK);
    wire       rd_data   = ahb_go & ~HWRITE_IN & (ap_addr == `I2CS_OFS_DATA);
    wire [7:0] wbyte     = HWDATA_IN[7:0];

    // Write data seen through each register's own layout
    wire i2cs_pkg::i2cs_ctl_two_t wr_ctl_v = wbyte;
    wire i2cs_pkg::i2cs_tmo_ctl_t wr_tmo_v = wbyte;
    wire i2cs_pkg::i2cs_irq_t     wr_irq_v = wbyte[$bits(i2cs_pkg::i2cs_irq_t)-1:0];

    // Link edges from synchronised pins
    wire scl_rise = scl_s2 & ~scl_s3;
    wire scl_fall = ~scl_s2 & scl_s3;

    // Lockup timer
    wire tick     = (pre_cnt == 32'(TICK_CYC - 1));
    wire tmo_fire = tmo_run & tmo.lockup_timer_enable & tick
                  & (tick_cnt == tmo.lockup_period_select);

    wire release_hold = ctl2.htx ? wr_data : rd_data;
    wire last_bit     = (bit_cnt == `I2CS_BYTE_LAST);

    function automatic logic [7:0] reg_mux(
        input logic [7:0]              a,
        input logic [7:0]              d,
        input i2cs_pkg::i2cs_ctl_two_t c,
        input i2cs_pkg::i2cs_tmo_ctl_t t,
        input i2cs_pkg::i2cs_irq_t     s,
        input i2cs_pkg::i2cs_irq_t     m
    );
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            `I2CS_OFS_DATA: r = d;
            `I2CS_OFS_CTL2: r = c;
            `I2CS_OFS_TMO:  r = t;
            `I2CS_OFS_IST:  r = {5'h00, s};
            `I2CS_OFS_IMSK: r = {5'h00, m};
            default:        r = 8'h00;
        endcase
        return r;
    endfunction : reg_mux

    always_comb begin
        next_state = state;
        unique case (state)
            i2cs_pkg::ST_IDLE: begin
            end
            i2cs_pkg::ST_HOLD: begin
                if (release_hold) begin
                    next_state = i2cs_pkg::ST_XFER;
                end
            end
            i2cs_pkg::ST_XFER: begin
                if (scl_fall && last_bit) begin
                    next_state = i2cs_pkg::ST_ACK;
                end
            end
            i2cs_pkg::ST_ACK: begin
                if (scl_fall) begin
                    // No ack either way ends the byte stream
                    if (ctl2.htx ? ctl2.ack_received_flag : ctl2.ack_to_send) begin
                        next_state = i2cs_pkg::ST_WAITSTOP;
                    end else begin
                        next_state = i2cs_pkg::ST_HOLD;
                    end
                end
            end
            i2cs_pkg::ST_WAITSTOP: begin
            end
        endcase
        if (ADDR_MATCH_IN) begin
            next_state = i2cs_pkg::ST_HOLD;
        end
        if (STOP_DET_IN || tmo_fire) begin
            next_state = i2cs_pkg::ST_IDLE;
        end
    end

    // Open-drain drive levels
    wire sda_low = (state == i2cs_pkg::ST_XFER &&  ctl2.htx) ? ~shift[7]
                 : (state == i2cs_pkg::ST_ACK  && ~ctl2.htx) ? ~ctl2.ack_to_send
                 : 1'b0;

    always_comb begin
        ev            = `I2CS_IRQ_RST;
        ev.addr_match = ADDR_MATCH_IN;
        ev.byte_done  = (state == i2cs_pkg::ST_ACK) & scl_fall;
        ev.lockup     = tmo_fire;
    end

    // Pin synchronisers
    always_ff @(posedge MCLK_IN) begin
        scl_s1 <= SCL_IN;
        scl_s2 <= scl_s1;
        scl_s3 <= scl_s2;
        sda_s1 <= SDA_IN;
        sda_s2 <= sda_s1;
    end

    // AHB-Lite slave, zero wait states
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            ph_wr         <= 1'b0;
            ph_addr       <= 8'h00;
            HRDATA_OUT    <= 32'h0000_0000;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
        end else begin
            ph_wr         <= ahb_go & HWRITE_IN;
            ph_addr       <= ap_addr;
            HRDATA_OUT    <= (ahb_go & ~HWRITE_IN)
                           ? {24'h00_0000, reg_mux(ap_addr, data_buf, ctl2, tmo, ist, imsk)}
                           : 32'h0000_0000;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            state <= i2cs_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Shifter and bit counter
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN || tmo_fire) begin
            shift   <= 8'h00;
            bit_cnt <= 3'h0;
        end else if (state == i2cs_pkg::ST_HOLD && release_hold) begin
            shift   <= ctl2.htx ? wbyte : 8'h00;
            bit_cnt <= 3'h0;
        end else if (state == i2cs_pkg::ST_XFER) begin
            if (!ctl2.htx && scl_rise) begin
                shift <= {shift[6:0], sda_s2};
            end
            if (scl_fall) begin
                bit_cnt <= bit_cnt + 3'h1;
                if (ctl2.htx) begin
                    shift <= {shift[6:0], 1'b0};
                end
            end
        end
    end

    // Shared data register survives a lockup
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            data_buf <= 8'h00;
        end else if (wr_data) begin
            data_buf <= wbyte;
        end else if (state == i2cs_pkg::ST_XFER && !ctl2.htx && scl_fall && last_bit) begin
            data_buf <= shift;
        end
    end

    // Control two
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN || tmo_fire) begin
            ctl2 <= `I2CS_CTL2_RST;
        end else begin
            if (wr_ctl2) begin
                ctl2.htx         <= wr_ctl_v.htx;
                ctl2.ack_to_send <= wr_ctl_v.ack_to_send;
            end
            if (ADDR_MATCH_IN) begin
                ctl2.srw          <= ADDR_RW_IN;
                ctl2.addr_matched <= 1'b1;
            end else if (STOP_DET_IN || release_hold) begin
                ctl2.addr_matched <= 1'b0;
            end
            if (state == i2cs_pkg::ST_ACK && ctl2.htx && scl_rise) begin
                ctl2.ack_received_flag <= sda_s2;
            end
        end
    end

    // Lockup timer control
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            tmo <= `I2CS_TMO_RST;
        end else begin
            if (wr_tmo) begin
                tmo.lockup_timer_enable  <= wr_tmo_v.lockup_timer_enable;
                tmo.lockup_period_select <= wr_tmo_v.lockup_period_select;
                if (!wr_tmo_v.lockup_timer_flag) begin
                    tmo.lockup_timer_flag <= 1'b0;
                end
            end
            // Hardware wins over a same-cycle write
            if (tmo_fire) begin
                tmo.lockup_timer_enable <= 1'b0;
                tmo.lockup_timer_flag   <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN || tmo_fire || STOP_DET_IN || !tmo.lockup_timer_enable) begin
            tmo_run <= 1'b0;
        end else if (ADDR_MATCH_IN) begin
            tmo_run <= 1'b1;
        end
    end

    // Prescaler gives one tick per 32 sub-clock periods
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN || !tmo_run || scl_fall || tick) begin
            pre_cnt <= 32'h0000_0000;
        end else begin
            pre_cnt <= pre_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN || !tmo_run || scl_fall || !tmo.lockup_timer_enable) begin
            tick_cnt <= 6'h00;
        end else if (tick) begin
            tick_cnt <= tick_cnt + 6'h01;
        end
    end

    // Plain cycle count beside the prescaler, only for the period check
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN || !tmo_run || scl_fall || !tmo.lockup_timer_enable) begin
            lk_cyc <= 32'h0000_0000;
        end else begin
            lk_cyc <= lk_cyc + 32'h0000_0001;
        end
    end

    // Interrupt status, write one to clear, set wins
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            ist  <= `I2CS_IRQ_RST;
            imsk <= `I2CS_IRQ_RST;
        end else begin
            ist <= (wr_ist ? (ist & ~wr_irq_v) : ist) | ev;
            if (wr_imsk) begin
                imsk <= wr_irq_v;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            IRQ_OUT    <= 1'b0;
            SCL_OE_OUT <= 1'b0;
            SDA_OE_OUT <= 1'b0;
            SCL_OUT    <= 1'b0;
            SDA_OUT    <= 1'b0;
        end else begin
            IRQ_OUT    <= |(ist & imsk);
            SCL_OE_OUT <= (next_state == i2cs_pkg::ST_HOLD);
            SDA_OE_OUT <= sda_low;
            SCL_OUT    <= 1'b0;
            SDA_OUT    <= 1'b0;
        end
    end

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    sequence lockup_seen;
        tmo_fire;
    endsequence

    sequence reset_to_idle;
        state == i2cs_pkg::ST_IDLE && ctl2 == `I2CS_CTL2_RST;
    endsequence

    hold_stretch_a: assert property (state == i2cs_pkg::ST_HOLD |-> SCL_OE_OUT)
        else $error("clock not held low while waiting on software");

    rel_hold_a: assert property (state == i2cs_pkg::ST_HOLD && release_hold
                                 && !ADDR_MATCH_IN && !STOP_DET_IN && !tmo_fire
                                 |=> !SCL_OE_OUT)
        else $error("clock still held after software service");

    lockup_flag_a: assert property (lockup_seen |=> tmo.lockup_timer_flag
                                     && !tmo.lockup_timer_enable)
        else $error("lockup did not set flag and clear enable");

    lockup_irq_a: assert property (lockup_seen ##0 imsk.lockup |=> ##1 IRQ_OUT)
        else $error("lockup gave no interrupt");

    lockup_reset_a: assert property (lockup_seen |=> reset_to_idle)
        else $error("lockup did not reset circuitry");

    fall_clear_a: assert property (scl_fall |=> tick_cnt == 6'h00)
        else $error("lockup count not cleared by clock fall");

    stop_halt_a: assert property (STOP_DET_IN |=> !tmo_run [*2])
        else $error("lockup count runs after stop");

    rx_ack_a: assert property ($past(state == i2cs_pkg::ST_ACK && !ctl2.htx)
                               |-> SDA_OE_OUT == !$past(ctl2.ack_to_send))
        else $error("wrong acknowledge level driven");

    nack_free_a: assert property (state == i2cs_pkg::ST_WAITSTOP |=> !SDA_OE_OUT)
        else $error("data line held after missing ack");

    byte_len_a: assert property ($rose(state == i2cs_pkg::ST_ACK) && !$past(STOP_DET_IN)
                                 |-> $past(bit_cnt) == `I2CS_BYTE_LAST)
        else $error("byte not eight bits");

    flag_sticky_a: assert property (tmo.lockup_timer_flag && !wr_tmo
                                    |=> tmo.lockup_timer_flag)
        else $error("lockup flag lost without software");

    fire_period_a: assert property (tmo_fire |-> lk_cyc ==
        (32'(tmo.lockup_period_select) + 32'h0000_0001) * 32'(TICK_CYC) - 32'h0000_0001)
        else $error("lockup period mismatch");

endmodule : i2cs_data_timeout

//--- verilog/i2cs_consts.svh
// Overview of operation
// - Eight data bits per byte after address ack
// - Data shifted most significant bit first
// - Receiver acknowledges each byte with low
// - Missing master ack releases data line
// - One shared data register for both directions
// - Receiver drives ack_to_send on ninth clock
// - Master ack recorded; no ack ends sending
// - Clock held low until data register serviced
// - Lockup count starts on match, cleared on fall
// - Period elapsed before next fall is lockup
// - Stop condition halts lockup counting
// - Overflow halts counter, clears enable, sets flag
// - Lockup raises the shared interrupt
// - Lockup resets circuitry and control two
// - Lockup flag set by hardware, cleared by software
// - Six-bit select gives (value+1)*32 sub periods
// - ack_to_send zero acks, one does not
// - ack_received_flag zero when master acknowledged
`ifndef I2CS_CONSTS_SVH
`define I2CS_CONSTS_SVH

`define I2CS_OFS_DATA   8'h00
`define I2CS_OFS_CTL2   8'h04
`define I2CS_OFS_TMO    8'h08
`define I2CS_OFS_IST    8'h0c
`define I2CS_OFS_IMSK   8'h10

`define I2CS_CTL2_RST   8'h01
`define I2CS_TMO_RST    8'h00
`define I2CS_IRQ_RST    3'h0

`define I2CS_BYTE_LAST  3'h7
`define I2CS_TMO_DIV    32

`endif

//--- verilog/i2cs_pkg.sv
package i2cs_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HOLD,
        ST_XFER,
        ST_ACK,
        ST_WAITSTOP
    } i2cs_state_t;

    // Layout equals the software view of the register
    typedef struct packed {
        logic rsv7;
        logic addr_matched;
        logic rsv5;
        logic htx;
        logic ack_to_send;
        logic srw;
        logic rsv1;
        logic ack_received_flag;
    } i2cs_ctl_two_t;

    typedef struct packed {
        logic       lockup_timer_enable;
        logic       lockup_timer_flag;
        logic [5:0] lockup_period_select;
    } i2cs_tmo_ctl_t;

    typedef struct packed {
        logic lockup;
        logic byte_done;
        logic addr_match;
    } i2cs_irq_t;

endpackage : i2cs_pkg

//--- bench/i2cs_master_model.sv
`timescale 1ns/1ps
module i2cs_master_model (
    output logic      scl_drv_out,
    output logic      sda_drv_out,
    input  wire logic scl_line_in,
    input  wire logic sda_line_in
);
    localparam real HALF = 62.5;
    int stalls;
    initial begin
        scl_drv_out = 1'b1;
        sda_drv_out = 1'b1;
        stalls      = 0;
    end
    // Stretch wait is bounded so a stuck slave cannot hang the run
    task automatic rise(output logic s);
        int n;
        scl_drv_out = 1'b1;
        n = 0;
        while (scl_line_in !== 1'b1 && n < 4000) begin
            #10;
            n++;
        end
        if (n >= 4000) stalls++;
        #(HALF / 2);
        s = sda_line_in;
        #(HALF / 2);
    endtask : rise
    task automatic bit_io(input logic v, output logic s);
        sda_drv_out = v;
        #(HALF / 2);
        rise(s);
        scl_drv_out = 1'b0;
        #(HALF / 2);
    endtask : bit_io
    task automatic start_c();
        logic s;
        sda_drv_out = 1'b0;
        #(HALF / 2);
        scl_drv_out = 1'b0;
        #(HALF / 2);
    endtask : start_c
    task automatic stop_c();
        logic s;
        sda_drv_out = 1'b0;
        #(HALF / 2);
        rise(s);
        sda_drv_out = 1'b1;
        #(HALF);
    endtask : stop_c
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(b[i], ack);
        bit_io(1'b1, ack);
    endtask : put_byte
    task automatic get_byte(input logic ackv, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(ackv, s);
    endtask : get_byte
endmodule : i2cs_master_model

//--- bench/tb_i2c_slave_data_ack_timeout.sv
`timescale 1ns/1ps
`include "i2cs_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_i2c_slave_data_ack_timeout;
    localparam int TICK = 20;
    localparam int EXP  = 3 * TICK;
    logic        clk, rst_n, hsel, hwrite, am, arw, stp, ack;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic        hready, hresp, scl_o, scl_oe, sda_o, sda_oe, irq;
    logic [7:0]  b;
    wire         scl_m, sda_m, scl_w, sda_w;
    int          num_errors, total_checks, n;
    assign scl_w = scl_m & ~(scl_oe & ~scl_o);
    assign sda_w = sda_m & ~(sda_oe & ~sda_o);
    i2cs_data_timeout #(.TICK_CYC(TICK)) dut (
        .MCLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
        .HRESP_OUT(hresp), .SCL_IN(scl_w), .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe),
        .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .ADDR_MATCH_IN(am),
        .ADDR_RW_IN(arw), .STOP_DET_IN(stp), .IRQ_OUT(irq));
    i2cs_master_model mst (.scl_drv_out(scl_m), .sda_drv_out(sda_m),
        .scl_line_in(scl_w), .sda_line_in(sda_w));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (k >= 50) begin
            num_errors++;
            $display("[FAIL] hready wait expired");
            finish_test();
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask : bus
    task automatic expect_reg(string nm, logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(nm, e, rd)
    endtask : expect_reg
    task automatic pulse(input logic m, input logic rw);
        @(posedge clk);
        am  <= m;
        arw <= rw;
        stp <= ~m;
        @(posedge clk);
        am  <= 1'b0;
        stp <= 1'b0;
    endtask : pulse
    // Either a stop or a disable must keep the lockup from firing
    task automatic lock_try(input logic use_stop);
        bus(1'b1, `I2CS_OFS_TMO, 8'h82);
        mst.start_c();
        pulse(1'b1, 1'b0);
        repeat (30) @(posedge clk);
        if (use_stop) pulse(1'b0, 1'b0);
        else bus(1'b1, `I2CS_OFS_TMO, 8'h02);
        repeat (100) @(posedge clk);
        expect_reg("tmo kept", `I2CS_OFS_TMO, use_stop ? 32'h82 : 32'h02);
        expect_reg("no lockup", `I2CS_OFS_IST, 32'h3);
        if (!use_stop) pulse(1'b0, 1'b0);
        mst.stop_c();
        bus(1'b1, `I2CS_OFS_TMO, 8'h00);
        $display("test lock_try %0d done", use_stop);
    endtask : lock_try
    initial begin
        num_errors = 0;
        total_checks = 0;
        rst_n = 1'b0;
        {hsel, hwrite, am, arw, stp} = '0;
        htrans = 2'h0;
        haddr  = '0;
        hwdata = '0;
        #900000;
        num_errors++;
        $display("[FAIL] run time limit");
        finish_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        expect_reg("data rst", `I2CS_OFS_DATA, 32'h0);
        expect_reg("ctl2 rst", `I2CS_OFS_CTL2, {24'h0, `I2CS_CTL2_RST});
        expect_reg("tmo rst", `I2CS_OFS_TMO, {24'h0, `I2CS_TMO_RST});
        expect_reg("ist rst", `I2CS_OFS_IST, 32'h0);
        expect_reg("imsk rst", `I2CS_OFS_IMSK, 32'h0);
        bus(1'b1, 8'h14, 8'hff);
        expect_reg("unmapped", 8'h14, 32'h0);
        $display("test regs done");
        mst.start_c();
        pulse(1'b1, 1'b0);
        repeat (4) @(posedge clk);
        `CHK("hold", 1'b1, scl_oe)
        `CHK("od levels", 2'b00, {scl_o, sda_o})
        bus(1'b1, `I2CS_OFS_CTL2, 8'h00);
        bus(1'b0, `I2CS_OFS_DATA, 8'h00);
        repeat (3) @(posedge clk);
        `CHK("release", 1'b0, scl_oe)
        mst.put_byte(8'ha5, ack);
        `CHK("rx ack", 1'b0, ack)
        repeat (4) @(posedge clk);
        `CHK("hold2", 1'b1, scl_oe)
        `CHK("irq masked", 1'b0, irq)
        expect_reg("byte done", `I2CS_OFS_IST, 32'h3);
        bus(1'b1, `I2CS_OFS_IMSK, 8'h02);
        repeat (2) @(posedge clk);
        `CHK("irq on", 1'b1, irq)
        bus(1'b1, `I2CS_OFS_IST, 8'h02);
        repeat (2) @(posedge clk);
        `CHK("irq clr", 1'b0, irq)
        bus(1'b1, `I2CS_OFS_CTL2, 8'h08);
        expect_reg("rx byte", `I2CS_OFS_DATA, 32'ha5);
        mst.put_byte(8'h3c, ack);
        `CHK("rx nack", 1'b1, ack)
        expect_reg("rx byte2", `I2CS_OFS_DATA, 32'h3c);
        mst.stop_c();
        pulse(1'b0, 1'b0);
        $display("test receive done");
        mst.start_c();
        pulse(1'b1, 1'b1);
        repeat (4) @(posedge clk);
        bus(1'b0, `I2CS_OFS_CTL2, 8'h00);
        `CHK("srw", 1'b1, rd[2])
        bus(1'b1, `I2CS_OFS_CTL2, 8'h10);
        bus(1'b1, `I2CS_OFS_DATA, 8'hc3);
        mst.get_byte(1'b0, b);
        `CHK("tx byte", 8'hc3, b)
        bus(1'b0, `I2CS_OFS_CTL2, 8'h00);
        `CHK("ack seen", 1'b0, rd[0])
        `CHK("tx hold", 1'b1, scl_oe)
        bus(1'b1, `I2CS_OFS_DATA, 8'h5a);
        mst.get_byte(1'b1, b);
        `CHK("tx byte2", 8'h5a, b)
        repeat (4) @(posedge clk);
        `CHK("sda free", 1'b0, sda_oe)
        bus(1'b0, `I2CS_OFS_CTL2, 8'h00);
        `CHK("nack seen", 1'b1, rd[0])
        mst.stop_c();
        pulse(1'b0, 1'b0);
        $display("test transmit done");
        bus(1'b1, `I2CS_OFS_IMSK, 8'h04);
        bus(1'b1, `I2CS_OFS_TMO, 8'h82);
        mst.start_c();
        pulse(1'b1, 1'b0);
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        `CHK("lock time", 1'b1, n >= EXP - 2 && n <= EXP + 4)
        `CHK("stretch off", 1'b0, scl_oe)
        repeat (100) @(posedge clk);
        expect_reg("tmo fired", `I2CS_OFS_TMO, 32'h42);
        expect_reg("ctl2 reset", `I2CS_OFS_CTL2, 32'h01);
        expect_reg("data kept", `I2CS_OFS_DATA, 32'h5a);
        bus(1'b1, `I2CS_OFS_TMO, 8'h40);
        expect_reg("flag kept", `I2CS_OFS_TMO, 32'h40);
        bus(1'b1, `I2CS_OFS_TMO, 8'h00);
        expect_reg("flag clr", `I2CS_OFS_TMO, 32'h00);
        bus(1'b1, `I2CS_OFS_IST, 8'h04);
        repeat (2) @(posedge clk);
        `CHK("irq lock clr", 1'b0, irq)
        mst.stop_c();
        pulse(1'b0, 1'b0);
        $display("test lockup done");
        lock_try(1'b1);
        lock_try(1'b0);
        `CHK("stalls", 0, mst.stalls)
        finish_test();
    end
endmodule : tb_i2c_slave_data_ack_timeout
